// ---- dcfifo_pkg.sv ----
// constants shared by the dual-clock fifo with programmable flags
package dcfifo_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int DATA_W = 9;
  localparam int DEPTH = 8192;
  localparam int ADDR_W = 13;
  localparam int PTR_W = ADDR_W + 1;
  localparam int OFF_LOW_W = 8;
  localparam int OFF_HIGH_W = ADDR_W - OFF_LOW_W;
  localparam int OFF_W = ADDR_W;
  localparam int NUM_OFFSETS = 4;

  // ----------------------------------------------------------------
  // pin sampling: position of each pin in the synchroniser vector
  // ----------------------------------------------------------------
  localparam int PIN_W = DATA_W + 8;
  localparam int PIN_WCLK = 0;
  localparam int PIN_RCLK = 1;
  localparam int PIN_WEN_A = 2;
  localparam int PIN_WEN_B_LD = 3;
  localparam int PIN_REN_A = 4;
  localparam int PIN_REN_B = 5;
  localparam int PIN_RESET = 6;
  localparam int PIN_OE = 7;
  localparam int PIN_DATA = 8;

  // ----------------------------------------------------------------
  // offset registers: rotating selector positions and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_EMPTY_LOW = 2'h0;
  localparam logic [1:0] SEL_EMPTY_HIGH = 2'h1;
  localparam logic [1:0] SEL_FULL_LOW = 2'h2;
  localparam logic [1:0] SEL_FULL_HIGH = 2'h3;
  localparam logic [7:0] OFFSET_LOW_RST = 8'h07;
  localparam logic [7:0] OFFSET_HIGH_RST = 8'h00;
  localparam logic [7:0] OFFSET_HIGH_MASK = 8'h1f;

  // ----------------------------------------------------------------
  // data, mode and pointer reset values, and the depth in pointer width
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] DATA_RST = 9'h000;
  localparam logic MODE_DUAL_RST = 1'b1;
  localparam logic [PTR_W-1:0] PTR_RST = 14'h0000;
  localparam logic [PTR_W-1:0] DEPTH_PTR = 14'h2000;

endpackage

// ---- dcfifo_sync.sv ----
// two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ns
module dcfifo_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // pins and synchronised copy
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one;

  // stage_one feeds only the second flop; nothing else may read it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_one <= '0;
      sync_out <= '0;
    end else if (ce) begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end

endmodule

// ---- dcfifo_top.sv ----
// dual-clock 9-bit fifo with empty, full and programmable almost flags
`timescale 1ns/1ns
module dcfifo_top
  import dcfifo_pkg::*;
(
  // system clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // write port pins
  input wire logic write_clock,
  input wire logic [DATA_W-1:0] data_in,
  input wire logic write_enable_a_n,
  input wire logic write_enable_b_or_load,
  // read port pins
  input wire logic read_clock,
  input wire logic read_enable_a_n,
  input wire logic read_enable_b_n,
  input wire logic output_enable_n,
  // device reset pin
  input wire logic reset_n,
  // data output pins
  output logic [DATA_W-1:0] data_out,
  output logic data_out_oe,
  // status flags
  output logic empty_flag_n,
  output logic full_flag_n,
  output logic almost_empty_flag_n,
  output logic almost_full_flag_n
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction

  function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b = '0;
    b[PTR_W-1] = g[PTR_W-1];
    for (int i = PTR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    gray2bin = b;
  endfunction

  // high offset registers keep only the bits a depth-sized offset needs
  function automatic logic [7:0] offset_mask(input logic [1:0] sel, input logic [7:0] v);
    if (sel == SEL_EMPTY_HIGH || sel == SEL_FULL_HIGH) begin
      offset_mask = v & OFFSET_HIGH_MASK;
    end else begin
      offset_mask = v;
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  logic [PIN_W-1:0] pins_async;
  logic [PIN_W-1:0] pins;

  // enable/load travels inverted so a cleared synchroniser reads as dual-enable mode
  assign pins_async = {data_in, output_enable_n, reset_n, read_enable_b_n,
                       read_enable_a_n, ~write_enable_b_or_load, write_enable_a_n,
                       read_clock, write_clock};

  // clocks, enables and data pass the same two stages, so they stay aligned
  dcfifo_sync #(
    .WIDTH(PIN_W)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .async_in(pins_async),
    .sync_out(pins)
  );

  logic wclk_s;
  logic rclk_s;
  logic wen_a_n_s;
  logic wen_b_ld_s;
  logic ren_a_n_s;
  logic ren_b_n_s;
  logic in_reset;
  logic oe_n_s;
  logic [DATA_W-1:0] din_s;

  assign wclk_s = pins[PIN_WCLK];
  assign rclk_s = pins[PIN_RCLK];
  assign wen_a_n_s = pins[PIN_WEN_A];
  assign wen_b_ld_s = ~pins[PIN_WEN_B_LD];
  assign ren_a_n_s = pins[PIN_REN_A];
  assign ren_b_n_s = pins[PIN_REN_B];
  assign in_reset = ~pins[PIN_RESET];
  assign oe_n_s = pins[PIN_OE];
  assign din_s = pins[PIN_DATA +: DATA_W];

  // ----------------------------------------------------------------
  // clock edge detection
  // ----------------------------------------------------------------
  logic wclk_q;
  logic rclk_q;
  logic wr_edge;
  logic rd_edge;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wclk_q <= 1'b0;
      rclk_q <= 1'b0;
    end else if (ce) begin
      wclk_q <= wclk_s;
      rclk_q <= rclk_s;
    end
  end

  assign wr_edge = wclk_s & ~wclk_q;
  assign rd_edge = rclk_s & ~rclk_q;

  // ----------------------------------------------------------------
  // configuration captured while the reset pin is low
  // ----------------------------------------------------------------
  logic mode_dual;
  logic load_active;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_dual <= MODE_DUAL_RST;
    end else if (ce && in_reset) begin
      mode_dual <= wen_b_ld_s;
    end
  end

  assign load_active = ~mode_dual & ~wen_b_ld_s;

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  logic wr_fifo;
  logic wr_off;
  logic rd_en;
  logic rd_off;
  logic rd_fifo;

  // dual mode needs the second enable high; load mode needs load high
  // for buffer writes, so both reduce to the same term
  assign wr_fifo = wr_edge & ~in_reset & ~wen_a_n_s & wen_b_ld_s & full_flag_n;
  assign wr_off = wr_edge & ~in_reset & load_active & ~wen_a_n_s;
  assign rd_en = rd_edge & ~in_reset & ~ren_a_n_s & ~ren_b_n_s;
  assign rd_off = rd_en & load_active;
  assign rd_fifo = rd_en & ~load_active & empty_flag_n;

  // ----------------------------------------------------------------
  // offset registers
  // ----------------------------------------------------------------
  logic [7:0] offset_reg [NUM_OFFSETS];
  logic [1:0] wr_sel;
  logic [1:0] rd_sel;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_OFFSETS; i++) begin
        offset_reg[i] <= i[0] ? OFFSET_HIGH_RST : OFFSET_LOW_RST;
      end
    end else if (ce) begin
      if (in_reset) begin
        for (int i = 0; i < NUM_OFFSETS; i++) begin
          offset_reg[i] <= i[0] ? OFFSET_HIGH_RST : OFFSET_LOW_RST;
        end
      end else if (wr_off) begin
        offset_reg[wr_sel] <= offset_mask(wr_sel, din_s[7:0]);
      end
    end
  end

  // selectors step on offset accesses and return to SEL_EMPTY_LOW on device reset, so releasing load keeps them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_sel <= SEL_EMPTY_LOW;
      rd_sel <= SEL_EMPTY_LOW;
    end else if (ce) begin
      if (in_reset) begin
        wr_sel <= SEL_EMPTY_LOW;
        rd_sel <= SEL_EMPTY_LOW;
      end else begin
        if (wr_off) begin
          wr_sel <= wr_sel + 2'h1;
        end
        if (rd_off) begin
          rd_sel <= rd_sel + 2'h1;
        end
      end
    end
  end

  logic [OFF_W-1:0] empty_offset;
  logic [OFF_W-1:0] full_offset;

  assign empty_offset = {offset_reg[SEL_EMPTY_HIGH][OFF_HIGH_W-1:0], offset_reg[SEL_EMPTY_LOW]};
  assign full_offset = {offset_reg[SEL_FULL_HIGH][OFF_HIGH_W-1:0], offset_reg[SEL_FULL_LOW]};

  // ----------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wptr;
  logic [PTR_W-1:0] rptr;
  logic [PTR_W-1:0] next_wptr;
  logic [PTR_W-1:0] next_rptr;

  assign next_wptr = wptr + PTR_W'(wr_fifo);
  assign next_rptr = rptr + PTR_W'(rd_fifo);

  // array write has no reset; contents are undefined until written
  always_ff @(posedge clk) begin
    if (ce && wr_fifo) begin
      mem[wptr[ADDR_W-1:0]] <= din_s;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr <= PTR_RST;
      rptr <= PTR_RST;
    end else if (ce) begin
      if (in_reset) begin
        wptr <= PTR_RST;
        rptr <= PTR_RST;
      end else begin
        wptr <= next_wptr;
        rptr <= next_rptr;
      end
    end
  end

  // ----------------------------------------------------------------
  // pointer exchange between write and read sides
  // ----------------------------------------------------------------
  logic [PTR_W-1:0] wptr_gray;
  logic [PTR_W-1:0] rptr_gray;
  logic [PTR_W-1:0] wptr_gray_seen;
  logic [PTR_W-1:0] rptr_gray_seen;
  logic [PTR_W-1:0] wptr_seen;
  logic [PTR_W-1:0] rptr_seen;

  // gray copies change one bit per step, so a side sampling mid-move sees
  // either the old or the new count and never a torn value
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_gray <= PTR_RST;
      rptr_gray <= PTR_RST;
      wptr_gray_seen <= PTR_RST;
      rptr_gray_seen <= PTR_RST;
    end else if (ce) begin
      if (in_reset) begin
        wptr_gray <= PTR_RST;
        rptr_gray <= PTR_RST;
        wptr_gray_seen <= PTR_RST;
        rptr_gray_seen <= PTR_RST;
      end else begin
        wptr_gray <= bin2gray(next_wptr);
        rptr_gray <= bin2gray(next_rptr);
        wptr_gray_seen <= wptr_gray;
        rptr_gray_seen <= rptr_gray;
      end
    end
  end

  assign wptr_seen = gray2bin(wptr_gray_seen);
  assign rptr_seen = gray2bin(rptr_gray_seen);

  // ----------------------------------------------------------------
  // flag computation
  // ----------------------------------------------------------------
  logic [PTR_W-1:0] wr_count;
  logic [PTR_W-1:0] rd_count;
  logic [PTR_W-1:0] full_thresh;

  assign wr_count = next_wptr - rptr_seen;
  assign rd_count = wptr_seen - next_rptr;
  assign full_thresh = DEPTH_PTR - {1'b0, full_offset};

  // read side flags update only on detected read clock edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      empty_flag_n <= 1'b0;
      almost_empty_flag_n <= 1'b0;
    end else if (ce) begin
      if (in_reset) begin
        empty_flag_n <= 1'b0;
        almost_empty_flag_n <= 1'b0;
      end else if (rd_edge) begin
        empty_flag_n <= (rd_count != PTR_RST);
        almost_empty_flag_n <= (rd_count > {1'b0, empty_offset});
      end
    end
  end

  // write side flags update only on detected write clock edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      full_flag_n <= 1'b1;
      almost_full_flag_n <= 1'b1;
    end else if (ce) begin
      if (in_reset) begin
        full_flag_n <= 1'b1;
        almost_full_flag_n <= 1'b1;
      end else if (wr_edge) begin
        full_flag_n <= (wr_count != DEPTH_PTR);
        almost_full_flag_n <= (wr_count < full_thresh);
      end
    end
  end

  // ----------------------------------------------------------------
  // output register and bus drive
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= DATA_RST;
    end else if (ce) begin
      if (in_reset) begin
        data_out <= DATA_RST;
      end else if (rd_off) begin
        data_out <= {1'b0, offset_reg[rd_sel]};
      end else if (rd_fifo) begin
        data_out <= mem[rptr[ADDR_W-1:0]];
      end
      // otherwise the last valid word stays, including reads while empty
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out_oe <= 1'b0;
    end else if (ce) begin
      data_out_oe <= ~oe_n_s;
    end
  end

endmodule

// ---- dcfifo_top_assertions.sv ----
// pin-level assertions for the dual-clock fifo
`timescale 1ns/1ns
module dcfifo_top_checker
  import dcfifo_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins in
  input wire logic write_clock,
  input wire logic read_clock,
  input wire logic output_enable_n,
  input wire logic reset_n,
  // pins out
  input wire logic [DATA_W-1:0] data_out,
  input wire logic data_out_oe,
  input wire logic empty_flag_n,
  input wire logic full_flag_n,
  input wire logic almost_empty_flag_n,
  input wire logic almost_full_flag_n
);
  // ----
  // pin histories
  // ----
  logic [5:0] wp;
  logic [5:0] rp;
  logic [3:0] dp;
  logic [1:0] up;
  logic w_rise;
  logic r_rise;
  logic quiet;
  // windows are loose: only the cause is pinned, not the sync latency
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp <= 6'h00;
      rp <= 6'h00;
      dp <= 4'h0;
      up <= 2'h0;
    end else begin
      wp <= {wp[4:0], write_clock};
      rp <= {rp[4:0], read_clock};
      dp <= {dp[2:0], reset_n};
      up <= (up == 2'h3) ? up : up + 2'h1;
    end
  end
  assign w_rise = |(wp[4:0] & ~wp[5:1]);
  assign r_rise = |(rp[4:0] & ~rp[5:1]);
  assign quiet = (&dp) & reset_n;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_reset_flags: assert property ((!reset_n) [*5] |-> !empty_flag_n &&
    !almost_empty_flag_n && full_flag_n && almost_full_flag_n) else $error("reset flags wrong");
  a_reset_data: assert property ((!reset_n) [*5] |-> data_out == DATA_RST)
    else $error("data not low in reset");
  a_oe_follow: assert property (up == 2'h3 |-> data_out_oe == !$past(output_enable_n, 3))
    else $error("bus drive wrong");
  a_full_wclk: assert property (($changed(full_flag_n) || $changed(almost_full_flag_n))
    && quiet |-> w_rise) else $error("full flags moved without write clock");
  a_empty_rclk: assert property (($changed(empty_flag_n) || $changed(almost_empty_flag_n))
    && quiet |-> r_rise) else $error("empty flags moved without read clock");
  a_empty_hold: assert property ($changed(empty_flag_n) |=>
    (!reset_n || $stable(empty_flag_n)) [*3]) else $error("empty flag too short");
  a_full_hold: assert property ($changed(full_flag_n) |=>
    (!reset_n || $stable(full_flag_n)) [*3]) else $error("full flag too short");
  a_empty_ae: assert property (!empty_flag_n |-> !almost_empty_flag_n)
    else $error("empty without almost empty");
  a_full_af: assert property (!full_flag_n |-> !almost_full_flag_n)
    else $error("full without almost full");
  a_data_read: assert property ($changed(data_out) && quiet |-> r_rise)
    else $error("data moved without read clock");

  c_full: cover property (!full_flag_n);
  c_ae_rise: cover property ($rose(almost_empty_flag_n));
  c_oe_fall: cover property ($fell(data_out_oe));
endmodule

bind dcfifo_top dcfifo_top_checker dcfifo_top_checker_inst (.clk(clk), .rst_n(rst_n),
  .write_clock(write_clock), .read_clock(read_clock), .output_enable_n(output_enable_n),
  .reset_n(reset_n), .data_out(data_out), .data_out_oe(data_out_oe),
  .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
  .almost_empty_flag_n(almost_empty_flag_n), .almost_full_flag_n(almost_full_flag_n));

// ---- dcfifo_peer.sv ----
// writer and reader logic that drives the fifo pins except output_enable_n, which the bench drives
`timescale 1ns/1ns
module dcfifo_peer
  import dcfifo_pkg::*;
(
  // clock and returned data
  input wire logic clk,
  input wire logic [DATA_W-1:0] data_out,
  // pins driven
  output logic write_clock,
  output logic [DATA_W-1:0] data_in,
  output logic write_enable_a_n,
  output logic write_enable_b_or_load,
  output logic read_clock,
  output logic read_enable_a_n,
  output logic read_enable_b_n,
  output logic reset_n
);
  // ----
  // pin tasks; pin clocks stand low between transfers
  // ----
  initial begin
    write_clock = 1'b0;
    data_in = 9'h000;
    write_enable_a_n = 1'b1;
    write_enable_b_or_load = 1'b1;
    read_clock = 1'b0;
    read_enable_a_n = 1'b1;
    read_enable_b_n = 1'b1;
    reset_n = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic dev_reset(input logic mode);
    tick(1);
    reset_n = 1'b0;
    write_enable_b_or_load = mode;
    tick(6);
    reset_n = 1'b1;
    write_enable_b_or_load = 1'b1;
    tick(2);
  endtask
  task automatic write_words(input int cnt, input logic [DATA_W-1:0] base, input logic ld,
    input logic en_n);
    write_enable_a_n = en_n;
    write_enable_b_or_load = ld;
    tick(1);
    for (int i = 0; i < cnt; i++) begin
      data_in = base + DATA_W'(i);
      write_clock = 1'b1;
      tick(2);
      write_clock = 1'b0;
      tick(2);
    end
    write_enable_a_n = 1'b1;
    write_enable_b_or_load = 1'b1;
    // a released line shows the inverse, never a stale copy
    data_in = ~data_in;
  endtask
  // en_n high gives a flag update only; never overlaps a write burst
  task automatic read_word(input logic ld, input logic en_n, output logic [DATA_W-1:0] q);
    read_enable_a_n = en_n;
    read_enable_b_n = en_n;
    write_enable_b_or_load = ld;
    tick(1);
    read_clock = 1'b1;
    tick(2);
    read_clock = 1'b0;
    tick(2);
    q = data_out;
    read_enable_a_n = 1'b1;
    read_enable_b_n = 1'b1;
    write_enable_b_or_load = 1'b1;
  endtask
endmodule

// ---- tb_top.sv ----
// self-checking bench for the dual-clock fifo
`timescale 1ns/1ns
module tb_top;
  import dcfifo_pkg::*;
  logic clk, rst_n, ce, output_enable_n, write_clock, write_enable_a_n;
  logic write_enable_b_or_load, read_clock, read_enable_a_n, read_enable_b_n;
  logic reset_n, data_out_oe, empty_flag_n, full_flag_n;
  logic almost_empty_flag_n, almost_full_flag_n;
  logic [DATA_W-1:0] data_in, data_out, q;
  int num_errors = 0;
  int tests_run = 0;

  dcfifo_top dcfifo_top_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .write_clock(write_clock),
    .data_in(data_in), .write_enable_a_n(write_enable_a_n),
    .write_enable_b_or_load(write_enable_b_or_load), .read_clock(read_clock),
    .read_enable_a_n(read_enable_a_n), .read_enable_b_n(read_enable_b_n),
    .output_enable_n(output_enable_n), .reset_n(reset_n), .data_out(data_out),
    .data_out_oe(data_out_oe), .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
    .almost_empty_flag_n(almost_empty_flag_n), .almost_full_flag_n(almost_full_flag_n));
  dcfifo_peer dcfifo_peer_inst (.clk(clk), .data_out(data_out), .write_clock(write_clock),
    .data_in(data_in), .write_enable_a_n(write_enable_a_n),
    .write_enable_b_or_load(write_enable_b_or_load), .read_clock(read_clock),
    .read_enable_a_n(read_enable_a_n), .read_enable_b_n(read_enable_b_n), .reset_n(reset_n));

  // ----
  // helpers
  // ----
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic test_done();
    if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check_flag(input string name, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic check_word(input string name, input logic [DATA_W-1:0] exp,
    input logic [DATA_W-1:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input int cnt, input logic [DATA_W-1:0] base, input logic ld);
    dcfifo_peer_inst.write_words(cnt, base, ld, 1'b0);
  endtask
  task automatic rd(input logic ld, input logic en_n);
    dcfifo_peer_inst.read_word(ld, en_n, q);
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_reset();
    dcfifo_peer_inst.dev_reset(1'b1);
    check_flag("empty", 1'b0, empty_flag_n);
    check_flag("almost_empty", 1'b0, almost_empty_flag_n);
    check_flag("full", 1'b1, full_flag_n);
    check_flag("almost_full", 1'b1, almost_full_flag_n);
    check_word("data_out", 9'h000, data_out);
  endtask
  task automatic t_stream();
    wr(9, 9'h100, 1'b1);
    rd(1'b1, 1'b1);
    check_flag("empty", 1'b1, empty_flag_n);
    check_flag("almost_empty", 1'b1, almost_empty_flag_n);
    for (int i = 0; i < 9; i++) begin
      rd(1'b1, 1'b0);
      check_word("data", 9'h100 + 9'(i), q);
      if (i < 2) rd(1'b1, 1'b1);
      if (i < 2) check_flag("almost_empty", i == 0, almost_empty_flag_n);
    end
    rd(1'b1, 1'b1);
    check_flag("empty", 1'b0, empty_flag_n);
    rd(1'b1, 1'b0);
    check_word("data", 9'h108, q);
    wr(1, 9'h0aa, 1'b0);
    rd(1'b1, 1'b1);
    check_flag("empty", 1'b0, empty_flag_n);
    wr(1, 9'h0ab, 1'b1);
    rd(1'b1, 1'b1);
    check_flag("empty", 1'b1, empty_flag_n);
    rd(1'b1, 1'b0);
    check_word("data", 9'h0ab, q);
  endtask
  task automatic t_oe();
    output_enable_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check_flag("oe", 1'b0, data_out_oe);
    output_enable_n = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check_flag("oe", 1'b1, data_out_oe);
  endtask
  task automatic t_full();
    dcfifo_peer_inst.dev_reset(1'b1);
    wr(8184, 9'h000, 1'b1);
    check_flag("almost_full", 1'b1, almost_full_flag_n);
    wr(1, 9'h000, 1'b1);
    check_flag("almost_full", 1'b0, almost_full_flag_n);
    wr(6, 9'h000, 1'b1);
    check_flag("full", 1'b1, full_flag_n);
    wr(1, 9'h000, 1'b1);
    // a lone device: its own empty and full flags are the composite ones
    check_flag("full", 1'b0, full_flag_n);
    wr(1, 9'h155, 1'b1);
    rd(1'b1, 1'b0);
    check_word("data", 9'h000, q);
    check_flag("full", 1'b0, full_flag_n);
  endtask
  task automatic t_offsets();
    logic [DATA_W-1:0] exp [4] = '{9'h002, 9'h000, 9'h003, 9'h01f};
    dcfifo_peer_inst.dev_reset(1'b0);
    for (int i = 0; i < 4; i++) begin
      rd(1'b0, 1'b0);
      check_word("offset", (i % 2 == 0) ? 9'h007 : 9'h000, q);
    end
    wr(1, 9'h002, 1'b0);
    wr(1, 9'h0e0, 1'b0);
    wr(1, 9'h003, 1'b0);
    wr(3, 9'h050, 1'b1);
    wr(1, 9'h1ff, 1'b0);
    rd(1'b1, 1'b1);
    check_flag("almost_empty", 1'b1, almost_empty_flag_n);
    for (int i = 0; i < 4; i++) begin
      rd(1'b0, 1'b0);
      check_word("offset", exp[i], q);
    end
    rd(1'b1, 1'b0);
    check_word("data", 9'h050, q);
    rd(1'b1, 1'b1);
    check_flag("almost_empty", 1'b0, almost_empty_flag_n);
  endtask

  initial begin
    ce = 1'b1;
    rst_n = 1'b0;
    output_enable_n = 1'b0;
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_stream();
    t_oe();
    t_full();
    t_offsets();
    test_done();
  end
  // the full-buffer pass dominates at about 33k cycles
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    test_done();
  end
endmodule
